// ### dv/smbal_core_asserts.sv
`timescale 1ns/10ps
module smbal_core_asserts #(
    parameter TIMEOUT_CYC = 200,
    parameter STATUS_CMD  = 8'h02
) (
    input wire       clk, rstn, scl_in,                      // Clock, reset, bus clock
    input wire       sda_out, sda_oe, alert_out, alert_oe,   // Pad drives
    input wire       overheat_out, overheat_oe,              // Overheat pad
    input wire [7:0] loc_temp, rem_temp, loc_high, loc_low,  // Temperatures, limits
    input wire [7:0] rem_high, rem_low, loc_ovt, rem_ovt,    // More limits
    input wire       diode_fault, cmd_wr, reg_wr, reg_rd,    // Fault and strobes
    input wire [7:0] reg_cmd,                                // Selected register
    input wire       alert_latched                           // Alarm state
);
    wire fault = loc_temp > loc_high || loc_temp < loc_low || rem_temp > rem_high
                 || rem_temp < rem_low || diode_fault;
    wire hot = loc_temp > loc_ovt || rem_temp > rem_ovt;
    reg [31:0] low_cnt;
    // Counts raw clock-low time; margin covers the filter delay
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            low_cnt <= 32'h0;
        else
            low_cnt <= scl_in ? 32'h0 : low_cnt + 32'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_stat_rd;
        reg_rd && reg_cmd == STATUS_CMD && !fault;
    endsequence
    sequence s_calm;
        !fault [*6];
    endsequence
    drive_low_a: assert property (!sda_out && !alert_out && !overheat_out)
        else $error("pad drive value not low");
    alert_set_a: assert property (fault |=> alert_oe && alert_latched)
        else $error("limit alarm missed a fault");
    alert_hold_a: assert property ($fell(alert_oe) |-> !$past(fault))
        else $error("limit alarm released during fault");
    latch_hold_a: assert property ($fell(alert_latched) |-> !$past(fault) && ($past(reg_rd) || $past(sda_oe, 2) && !$past(sda_oe)))
        else $error("alarm state cleared without acknowledge");
    alert_ack_a: assert property (s_stat_rd ##1 s_calm |=> !alert_oe && !alert_latched)
        else $error("limit alarm kept after status read");
    overheat_pin_a: assert property (1'b1 |=> overheat_oe == $past(hot))
        else $error("overheat drive wrong");
    bus_timeout_a: assert property (low_cnt > TIMEOUT_CYC + 8 |-> !sda_oe)
        else $error("data held after clock timeout");
    drive_edge_a: assert property ($rose(sda_oe) |-> !$past(scl_in) && !$past(scl_in, 5))
        else $error("data drive not after settled clock low");
    strobe_pulse_a: assert property (cmd_wr || reg_wr |=> !cmd_wr && !reg_wr)
        else $error("strobe longer than one cycle");
    cmd_track_a: assert property ($changed(reg_cmd) |-> cmd_wr)
        else $error("command changed without strobe");
endmodule

// ### dv/smbal_host.sv
`timescale 1ns/10ps
// Bus host: drives the clock line, pulls data low or leaves it to the pull-up
module smbal_host #(
    parameter H = 250
) (
    input  wire clk,    // System clock
    input  wire sda,    // Resolved data line
    output reg  scl,    // Clock line
    output reg  sda_h   // Host data drive, 0 pulls low
);
    reg spike;  // Adds 40 ns clock spikes in high phases
    initial begin
        scl = 1'b1;
        sda_h = 1'b1;
        spike = 1'b0;
    end
    task tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Start or repeated start; 100 kHz spacing as the bus asks
    task start;
        tick(H / 2);
        sda_h = 1'b1;
        tick(H / 2);
        scl = 1'b1;
        tick(H);
        sda_h = 1'b0;
        tick(H);
        scl = 1'b0;
    endtask
    task stop;
        tick(H / 2);
        sda_h = 1'b0;
        tick(H / 2);
        scl = 1'b1;
        tick(H);
        sda_h = 1'b1;
        tick(H);
    endtask
    // Data moves mid low phase, well clear of both clock edges
    task bitx(input b, output s);
        tick(H / 2);
        sda_h = b;
        tick(H / 2);
        scl = 1'b1;
        tick(H / 2);
        if (spike) begin
            scl = 1'b0;
            tick(2);
            scl = 1'b1;
        end
        tick(H / 2);
        s = sda;
        scl = 1'b0;
    endtask
    // Eight bits MSB first, then the ack bit with level m
    task xfer(input [7:0] d, input m, output [7:0] q, output a);
        integer i;
        reg     s;
        for (i = 7; i >= 0; i = i - 1) begin
            bitx(d[i], s);
            q[i] = s;
        end
        bitx(m, a);
    endtask
endmodule

// ### dv/smbus_alarm_interface_bench.sv
`timescale 1ns/10ps
module smbus_alarm_interface_bench;
    // Must exceed the 250-cycle clock low phase of the host
    localparam       TO = 400;
    localparam [6:0] ARA = 7'h0c;
    localparam       SC = 8'h02;
    localparam [6:0] ADDR = 7'h2a;
    localparam [7:0] RDATA = 8'ha5;
    reg        clk, rstn, diode_fault;
    reg  [7:0] loc_temp, rem_temp, loc_high, loc_low, rem_high, rem_low, loc_ovt, rem_ovt;
    wire       scl, sda_h, sda_out, sda_oe, alert_out, alert_oe, overheat_out, overheat_oe;
    wire       cmd_wr, reg_wr, reg_rd, alert_latched;
    wire [7:0] reg_cmd, reg_wdata;
    integer    error_cnt, total_checks, cyc;
    // Open-drain pins with pull-ups
    wire       sda = sda_h & ~(sda_oe & ~sda_out);
    wire       alert_n = alert_oe ? alert_out : 1'b1;
    wire       overheat_n = overheat_oe ? overheat_out : 1'b1;
    smbal_host host (.clk, .sda, .scl, .sda_h);
    smbal_core #(.TIMEOUT_CYC(TO), .STATUS_CMD(SC)) dut (.clk, .rstn, .scl_in(scl),
        .sda_in(sda), .sda_out, .sda_oe, .alert_out, .alert_oe, .overheat_out, .overheat_oe,
        .dev_addr(ADDR), .loc_temp, .rem_temp, .loc_high, .loc_low, .rem_high, .rem_low,
        .loc_ovt, .rem_ovt, .diode_fault, .reg_cmd, .cmd_wr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata(RDATA), .alert_latched);
    always #10 clk = ~clk;
    task cmp(input [7:0] got, input [7:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Write byte with clock spikes in the high phase of every bit
    task t_write;
        reg [7:0] q;
        reg       a;
        host.spike = 1'b1;
        host.start;
        host.xfer({ADDR, 1'b0}, 1'b1, q, a);
        cmp({7'h00, a}, 8'h00);
        host.xfer(8'h3c, 1'b1, q, a);
        host.xfer(8'h96, 1'b1, q, a);
        host.stop;
        host.spike = 1'b0;
        cmp(reg_cmd, 8'h3c);
        cmp(reg_wdata, 8'h96);
    endtask
    // Wrong address is left unanswered
    task t_refuse;
        reg [7:0] q;
        reg       a;
        host.start;
        host.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
        host.stop;
        cmp({7'h00, a}, 8'h01);
    endtask
    // Clock parked low while the slave holds its ack
    task t_timeout;
        integer i;
        reg     s;
        host.start;
        for (i = 7; i >= 0; i = i - 1)
            host.bitx(i == 0 ? 1'b0 : ADDR[i - 1], s);
        host.tick(20);
        cmp({7'h00, sda_oe}, 8'h01);
        host.tick(TO + 20);
        cmp({7'h00, sda_oe}, 8'h00);
        host.stop;
    endtask
    // Two-byte read of the status register; the host acknowledges the first byte and not the second
    task status_read(input exp_n);
        reg [7:0] q;
        reg       a;
        host.start;
        host.xfer({ADDR, 1'b0}, 1'b1, q, a);
        host.xfer(SC, 1'b1, q, a);
        host.start;
        host.xfer({ADDR, 1'b1}, 1'b1, q, a);
        host.xfer(8'hff, 1'b0, q, a);
        cmp(q, RDATA);
        host.xfer(8'hff, 1'b1, q, a);
        host.stop;
        cmp(q, RDATA);
        cmp({7'h00, alert_n}, {7'h00, exp_n});
    endtask
    task t_alarm;
        rem_temp = 8'h70;
        host.tick(3);
        cmp({6'h00, alert_n, overheat_n}, 8'h00);
        rem_temp = 8'h30;
        host.tick(3);
        cmp({6'h00, alert_n, overheat_n}, 8'h01);
        diode_fault = 1'b1;
        status_read(1'b0);
        diode_fault = 1'b0;
        loc_temp = 8'h05;
        host.tick(3);
        loc_temp = 8'h30;
        status_read(1'b1);
    endtask
    // Alert response address while the alarm is latched
    task t_ara;
        reg [7:0] q;
        reg       a;
        loc_temp = 8'h55;
        host.tick(3);
        loc_temp = 8'h30;
        host.tick(3);
        cmp({7'h00, alert_n}, 8'h00);
        host.start;
        host.xfer({ARA, 1'b1}, 1'b1, q, a);
        cmp({7'h00, a}, 8'h00);
        host.xfer(8'hff, 1'b1, q, a);
        host.stop;
        cmp(q, {ADDR, 1'b0});
        cmp({7'h00, alert_n}, 8'h01);
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 95000) begin
            error_cnt = error_cnt + 1;
            close_out;
        end
    end
    initial begin
        {clk, rstn, diode_fault} = 3'h0;
        {error_cnt, total_checks, cyc} = 0;
        {loc_temp, rem_temp, loc_ovt, rem_ovt} = {8'h30, 8'h30, 8'h60, 8'h60};
        {loc_high, loc_low, rem_high, rem_low} = {8'h50, 8'h10, 8'h50, 8'h10};
        repeat (10) @(posedge clk);
        #1;
        rstn = 1'b1;
        host.tick(5);
        t_write;
        t_refuse;
        t_timeout;
        t_alarm;
        t_ara;
        close_out;
    end
endmodule
bind smbal_core smbal_core_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC), .STATUS_CMD(STATUS_CMD)) chk (
    .clk, .rstn, .scl_in, .sda_out, .sda_oe, .alert_out, .alert_oe, .overheat_out,
    .overheat_oe, .loc_temp, .rem_temp, .loc_high, .loc_low, .rem_high, .rem_low, .loc_ovt,
    .rem_ovt, .diode_fault, .cmd_wr, .reg_wr, .reg_rd, .reg_cmd, .alert_latched);

// ### verilog/smbal_core.v
`timescale 1ns/10ps
`include "smbal_defs.vh"

// How it works
// - A clock line held low past the timeout returns the serial slave to idle.
// - The limit alarm asserts when either temperature is above its high or below its low limit.
// - The limit alarm holds until a status read or alert response and then drops only if the fault is gone.
// - The overheat output is pulled low while either temperature is above its overheat limit.
// - Data line and both alarms only pull low and otherwise float for a pull-up.
// - Spikes of 50 ns or less on clock and data are filtered out.
// - A shorted or open remote diode also asserts the limit alarm.
// - The slave answers write byte, read byte, send byte and receive byte at one address.
module smbal_core #(
    parameter TIMEOUT_CYC = `SMBAL_TIMEOUT_CYC,
    parameter TW          = 24,
    parameter STATUS_CMD  = 8'h02   // Command code of the status register, arbitrary default
) (
    input  wire         clk,           // System clock, 50 MHz
    input  wire         rstn,          // Async reset, active low
    input  wire         scl_in,        // Serial clock pin level
    input  wire         sda_in,        // Serial data pin level
    output reg          sda_out,       // Serial data drive value, always low
    output reg          sda_oe,        // Pulls serial data low when high
    output reg          alert_out,     // Limit alarm drive value, always low
    output reg          alert_oe,      // Pulls limit alarm low when high
    output reg          overheat_out,  // Overheat drive value, always low
    output reg          overheat_oe,   // Pulls overheat low when high
    input  wire [6:0]   dev_addr,      // Slave address
    input  wire [7:0]   loc_temp,      // Local temperature
    input  wire [7:0]   rem_temp,      // Remote temperature
    input  wire [7:0]   loc_high,      // Local high limit
    input  wire [7:0]   loc_low,       // Local low limit
    input  wire [7:0]   rem_high,      // Remote high limit
    input  wire [7:0]   rem_low,       // Remote low limit
    input  wire [7:0]   loc_ovt,       // Local overheat limit
    input  wire [7:0]   rem_ovt,       // Remote overheat limit
    input  wire         diode_fault,   // Remote diode short or open
    output reg  [7:0]   reg_cmd,       // Selected register
    output reg          cmd_wr,        // Pulse: command byte taken
    output reg          reg_wr,        // Pulse: data byte written
    output reg  [7:0]   reg_wdata,     // Written data
    output reg          reg_rd,        // Pulse: reg_rdata taken for sending
    input  wire [7:0]   reg_rdata,     // Read data of reg_cmd
    output reg          alert_latched  // Limit alarm state
);

    wire       scl;
    wire       sda;
    reg        scl_d;
    reg        sda_d;
    reg [2:0]  state;
    reg [1:0]  phase;
    reg [3:0]  cnt;
    reg [7:0]  sh;
    reg        is_read;
    reg        is_ara;
    reg        mack_ok;
    reg        ack_evt;
    reg [TW-1:0] tmo;

    ////////////////////////////////////////////////////////////////////////
    // Input spike filters
    smbal_glitch u_scl_flt (
        .clk   (clk),
        .rstn  (rstn),
        .raw   (scl_in),
        .clean (scl)
    );

    smbal_glitch u_sda_flt (
        .clk   (clk),
        .rstn  (rstn),
        .raw   (sda_in),
        .clean (sda)
    );

    // Bus events on the filtered levels
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start    = scl & scl_d & sda_d & ~sda;
    wire stop     = scl & scl_d & ~sda_d & sda;
    wire tmo_hit  = (tmo == TIMEOUT_CYC[TW-1:0]);

    // Fault conditions
    wire limit_fault = (loc_temp > loc_high) | (loc_temp < loc_low) |
                       (rem_temp > rem_high) | (rem_temp < rem_low);
    wire any_fault   = limit_fault | diode_fault;
    wire hot         = (loc_temp > loc_ovt) | (rem_temp > rem_ovt);

    ////////////////////////////////////////////////////////////////////////
    // Timeout counter; saturates so a stuck bus keeps the slave idle
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tmo <= {TW{1'b0}};
        end else if (scl) begin
            tmo <= {TW{1'b0}};
        end else if (!tmo_hit) begin
            tmo <= tmo + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarm outputs; set wins over acknowledge in the same cycle
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            alert_latched <= 1'b0;
            alert_oe      <= 1'b0;
            alert_out     <= 1'b0;
            overheat_oe   <= 1'b0;
            overheat_out  <= 1'b0;
        end else begin
            if (any_fault) begin
                alert_latched <= 1'b1;
            end else if (ack_evt) begin
                alert_latched <= 1'b0;
            end
            alert_oe    <= any_fault | (alert_latched & ~ack_evt);
            overheat_oe <= hot;
            alert_out    <= 1'b0;
            overheat_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial slave: sample on clock rise, change data on clock fall
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_d     <= 1'b1;
            sda_d     <= 1'b1;
            state     <= `SMBAL_ST_IDLE;
            phase     <= `SMBAL_PH_ADDR;
            cnt       <= 4'h0;
            sh        <= 8'h00;
            is_read   <= 1'b0;
            is_ara    <= 1'b0;
            mack_ok   <= 1'b0;
            ack_evt   <= 1'b0;
            sda_oe    <= 1'b0;
            sda_out   <= 1'b0;
            reg_cmd   <= 8'h00;
            cmd_wr    <= 1'b0;
            reg_wr    <= 1'b0;
            reg_wdata <= 8'h00;
            reg_rd    <= 1'b0;
        end else begin
            scl_d   <= scl;
            sda_d   <= sda;
            cmd_wr  <= 1'b0;
            reg_wr  <= 1'b0;
            reg_rd  <= 1'b0;
            ack_evt <= 1'b0;
            sda_out <= 1'b0;
            if (tmo_hit) begin
                state  <= `SMBAL_ST_IDLE;
                sda_oe <= 1'b0;
            end else if (start) begin
                // Start or repeated start: expect an address byte
                state  <= `SMBAL_ST_RX;
                phase  <= `SMBAL_PH_ADDR;
                cnt    <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop) begin
                state  <= `SMBAL_ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    `SMBAL_ST_RX: begin
                        if (scl_rise && cnt != `SMBAL_BITS) begin
                            sh  <= {sh[6:0], sda};
                            cnt <= cnt + 1'b1;
                        end else if (scl_fall && cnt == `SMBAL_BITS) begin
                            cnt <= 4'h0;
                            if (phase == `SMBAL_PH_ADDR) begin
                                // Own address, or alert response while alarmed
                                if (sh[7:1] == dev_addr) begin
                                    state   <= `SMBAL_ST_ACK;
                                    sda_oe  <= 1'b1;
                                    is_read <= (sh[0] == `SMBAL_RW_READ);
                                    is_ara  <= 1'b0;
                                    phase   <= `SMBAL_PH_CMD;
                                end else if (sh[7:1] == `SMBAL_ARA &&
                                             sh[0] == `SMBAL_RW_READ &&
                                             alert_latched) begin
                                    state   <= `SMBAL_ST_ACK;
                                    sda_oe  <= 1'b1;
                                    is_read <= 1'b1;
                                    is_ara  <= 1'b1;
                                end else begin
                                    state <= `SMBAL_ST_IDLE;
                                end
                            end else if (phase == `SMBAL_PH_CMD) begin
                                reg_cmd <= sh;
                                cmd_wr  <= 1'b1;
                                phase   <= `SMBAL_PH_DATA;
                                state   <= `SMBAL_ST_ACK;
                                sda_oe  <= 1'b1;
                            end else begin
                                // Only one data byte per write; later ones get no ack
                                reg_wdata <= sh;
                                reg_wr    <= 1'b1;
                                phase     <= `SMBAL_PH_ADDR;
                                state     <= `SMBAL_ST_ACK;
                                sda_oe    <= 1'b1;
                            end
                        end
                    end
                    `SMBAL_ST_ACK: begin
                        if (scl_fall) begin
                            if (is_read) begin
                                // Load reply and drive its first bit
                                sh      <= is_ara ? {dev_addr, 1'b0} : reg_rdata;
                                sda_oe  <= is_ara ? ~dev_addr[6] : ~reg_rdata[7];
                                reg_rd  <= ~is_ara;
                                ack_evt <= ~is_ara & (reg_cmd == STATUS_CMD);
                                cnt     <= 4'h1;
                                is_read <= 1'b0;
                                state   <= `SMBAL_ST_TX;
                            end else if (phase == `SMBAL_PH_ADDR) begin
                                sda_oe <= 1'b0;
                                state  <= `SMBAL_ST_IDLE;
                            end else begin
                                sda_oe <= 1'b0;
                                state  <= `SMBAL_ST_RX;
                            end
                        end
                    end
                    `SMBAL_ST_TX: begin
                        if (scl_fall) begin
                            if (cnt == `SMBAL_BITS) begin
                                sda_oe  <= 1'b0;
                                ack_evt <= is_ara;
                                state   <= `SMBAL_ST_MACK;
                            end else begin
                                sda_oe <= ~sh[6];
                                sh     <= {sh[6:0], 1'b0};
                                cnt    <= cnt + 1'b1;
                            end
                        end
                    end
                    `SMBAL_ST_MACK: begin
                        if (scl_rise) begin
                            mack_ok <= ~sda;
                        end else if (scl_fall) begin
                            // Master ack asks for another byte; its first bit
                            // must go out on this same fall, or the byte slips
                            if (mack_ok && !is_ara) begin
                                sh      <= reg_rdata;
                                sda_oe  <= ~reg_rdata[7];
                                reg_rd  <= 1'b1;
                                ack_evt <= (reg_cmd == STATUS_CMD);
                                cnt     <= 4'h1;
                                state   <= `SMBAL_ST_TX;
                            end else begin
                                state <= `SMBAL_ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

// ### verilog/smbal_defs.vh
`ifndef SMBAL_DEFS_VH
`define SMBAL_DEFS_VH

// Clock rate
`define SMBAL_CLK_MHZ       50

// Spike filter: pulses up to this width are ignored
`define SMBAL_SPIKE_NS      50
// Least time rounds up; one more cycle so a 50 ns spike never passes
`define SMBAL_SPIKE_CYC     ((`SMBAL_SPIKE_NS * `SMBAL_CLK_MHZ + 999) / 1000 + 1)

// Bus inactivity timeout (typical figure; legal window 25 ms to 55 ms)
`define SMBAL_TIMEOUT_MS    37
`define SMBAL_TIMEOUT_CYC   (`SMBAL_TIMEOUT_MS * `SMBAL_CLK_MHZ * 1000)

// Alert response address of the bus standard
`define SMBAL_ARA           7'h0c

// Byte handling
`define SMBAL_BITS          4'h8
`define SMBAL_RW_READ       1'b1

// Phases of a received byte
`define SMBAL_PH_ADDR       2'h0
`define SMBAL_PH_CMD        2'h1
`define SMBAL_PH_DATA       2'h2

// Slave states
`define SMBAL_ST_IDLE       3'h0
`define SMBAL_ST_RX         3'h1
`define SMBAL_ST_ACK        3'h2
`define SMBAL_ST_TX         3'h3
`define SMBAL_ST_MACK       3'h4

`endif

// ### verilog/smbal_glitch.v
`timescale 1ns/10ps
`include "smbal_defs.vh"

// Passes a level only after it has stood for CYC clocks
module smbal_glitch #(
    parameter CYC = `SMBAL_SPIKE_CYC,
    parameter CW  = 3
) (
    input  wire          clk,    // System clock
    input  wire          rstn,   // Async reset, active low
    input  wire          raw,    // Pin level
    output reg           clean   // Filtered level
);

    reg [CW-1:0] cnt;

    ////////////////////////////////////////////////////////////////////////
    // Count disagreement; any return to agreement restarts the count
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clean <= 1'b1;
            cnt   <= {CW{1'b0}};
        end else if (raw == clean) begin
            cnt <= {CW{1'b0}};
        end else if (cnt == CYC[CW-1:0] - 1'b1) begin
            clean <= raw;
            cnt   <= {CW{1'b0}};
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

endmodule
